// ===== inc/ssrw_consts.svh
// timing and reset constants for the supply supervisor
`ifndef SSRW_CONSTS_SVH
`define SSRW_CONSTS_SVH

// clock period in picoseconds (250 MHz)
`define SSRW_CLK_PERIOD_PS 64'd4000

// watchdog period, typical, in milliseconds
`define SSRW_WD_PERIOD_MS 64'd1600
`define SSRW_WD_CYCLES ((`SSRW_WD_PERIOD_MS * 64'd1000000000) / `SSRW_CLK_PERIOD_PS)

// reset release delay in milliseconds
`define SSRW_RST_DELAY_MS 64'd200
`define SSRW_RST_DELAY_CYCLES ((`SSRW_RST_DELAY_MS * 64'd1000000000) / `SSRW_CLK_PERIOD_PS)

// manual reset glitch filter time in nanoseconds, least time rounds up
`define SSRW_MR_FILTER_NS 64'd1000
`define SSRW_MR_FILTER_CYCLES ((`SSRW_MR_FILTER_NS * 64'd1000 + `SSRW_CLK_PERIOD_PS - 64'd1) / `SSRW_CLK_PERIOD_PS)

// counter widths
`define SSRW_FILT_CNT_W 16
`define SSRW_CNT_W 32

// filter stage and supervisor counter reset values
`define SSRW_SYNC_RESET 3'h7
`define SSRW_FILT_CNT_RESET 16'h0000
`define SSRW_CNT_RESET 32'h0000_0000

`endif

// ===== inc/ssrw_pkg.sv
// types shared by the supply supervisor modules
`include "ssrw_consts.svh"

package ssrw_pkg;

  // reset output drive style
  typedef enum {
    SSRW_OD_EXT,
    SSRW_OD_INT,
    SSRW_PP_LOW,
    SSRW_PP_HIGH
  } ssrw_out_kind_e;

  // input synchroniser and filter state
  typedef struct packed {
    logic [2:0] sync;
    logic [`SSRW_FILT_CNT_W-1:0] cnt;
    logic level;
    logic rise;
    logic fall;
  } ssrw_filt_s;

  // reset pin group as driven
  typedef struct packed {
    logic rst_n;
    logic rst_n_oe;
    logic rst_n_pullup;
    logic rst;
    logic rst_oe;
  } ssrw_pins_s;

  // supervisor core state
  typedef struct packed {
    logic undervolt;
    logic wd_armed;
    logic wd_timeout;
    logic [`SSRW_CNT_W-1:0] wd_cnt;
    logic [`SSRW_CNT_W-1:0] dly_cnt;
    logic active;
    ssrw_pins_s pins;
  } ssrw_state_s;

endpackage : ssrw_pkg

// ===== hdl/ssrw_pin_filter.sv
// three-stage synchroniser with stability filter and edge pulses
`timescale 1ns/1ps
`default_nettype none

module ssrw_pin_filter
  import ssrw_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = 1
) (
  // clock and control
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // raw pin
  input wire logic pin_in,
  // filtered level and edges
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  localparam logic [`SSRW_FILT_CNT_W-1:0] LAST = `SSRW_FILT_CNT_W'(FILTER_CYCLES - 1);

  ssrw_filt_s state_reg;
  ssrw_filt_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.rise = 1'b0;
    state_next.fall = 1'b0;
    state_next.sync = {state_reg.sync[1:0], pin_in};
    // stage 2 and 3 agreeing on a new value counts as a change
    if ((state_reg.sync[1] == state_reg.sync[2]) && (state_reg.sync[2] != state_reg.level)) begin
      // level must hold for the whole filter time before it is taken
      if (state_reg.cnt >= LAST) begin
        state_next.cnt = `SSRW_FILT_CNT_RESET;
        state_next.level = state_reg.sync[2];
        state_next.rise = state_reg.sync[2];
        state_next.fall = ~state_reg.sync[2];
      end else begin
        state_next.cnt = state_reg.cnt + `SSRW_FILT_CNT_W'(1);
      end
    end else begin
      state_next.cnt = `SSRW_FILT_CNT_RESET;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_reg <= '{sync: `SSRW_SYNC_RESET, cnt: `SSRW_FILT_CNT_RESET, level: 1'b1, rise: 1'b0, fall: 1'b0};
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.level;
  assign rise_out = state_reg.rise;
  assign fall_out = state_reg.fall;

endmodule : ssrw_pin_filter

`default_nettype wire

// ===== hdl/ssrw_supervisor.sv
// supply supervisor: reset causes, watchdog, release delay, output drivers
`timescale 1ns/1ps
`default_nettype none

module ssrw_supervisor
  import ssrw_pkg::*;
#(
  parameter ssrw_out_kind_e OUT_KIND = SSRW_PP_LOW,
  parameter bit DUAL_OUTPUT = 1'b0,
  parameter bit HAS_WATCHDOG = 1'b1,
  parameter bit HAS_MANUAL = 1'b1,
  parameter int unsigned WD_CYCLES = int'(`SSRW_WD_CYCLES),
  parameter int unsigned RST_DELAY_CYCLES = int'(`SSRW_RST_DELAY_CYCLES),
  parameter int unsigned MR_FILTER_CYCLES = int'(`SSRW_MR_FILTER_CYCLES)
) (
  // clock and control
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // supply comparator levels
  input wire logic supply_below_trip_in,
  input wire logic supply_above_hyst_in,
  // host and push-button pins
  input wire logic manual_reset_n_in,
  input wire logic watchdog_kick_in,
  // active-low reset pin
  output logic rst_n_out,
  output logic rst_n_oe_out,
  output logic rst_n_pullup_out,
  // active-high reset pin
  output logic rst_out,
  output logic rst_oe_out,
  // status
  output logic reset_active_out,
  output logic wd_armed_out
);

  localparam logic [`SSRW_CNT_W-1:0] WD_LAST = `SSRW_CNT_W'(WD_CYCLES - 1);
  localparam logic [`SSRW_CNT_W-1:0] DLY_LAST = `SSRW_CNT_W'(RST_DELAY_CYCLES - 1);

  logic below_lvl;
  logic above_lvl;
  logic manual_lvl;
  logic kick_rise;
  logic kick_fall;

  ssrw_state_s state_reg;
  ssrw_state_s state_next;

  // pin drive pattern for a given internal reset state
  function automatic ssrw_pins_s drive_pins(input logic asserted);
    ssrw_pins_s p;
    p = '0;
    unique case (OUT_KIND)
      SSRW_OD_EXT: begin
        p.rst_n = 1'b0;
        p.rst_n_oe = asserted;
        p.rst_n_pullup = 1'b0;
      end
      SSRW_OD_INT: begin
        p.rst_n = 1'b0;
        p.rst_n_oe = asserted;
        p.rst_n_pullup = 1'b1;
      end
      SSRW_PP_LOW: begin
        p.rst_n = ~asserted;
        p.rst_n_oe = 1'b1;
        p.rst_n_pullup = 1'b0;
      end
      SSRW_PP_HIGH: begin
        p.rst_n = 1'b1;
        p.rst_n_oe = 1'b0;
        p.rst_n_pullup = 1'b0;
      end
    endcase
    // both pins come from the one internal state, except that SSRW_PP_HIGH leaves the active-low pin undriven
    p.rst = asserted;
    p.rst_oe = DUAL_OUTPUT || (OUT_KIND == SSRW_PP_HIGH);
    return p;
  endfunction : drive_pins

  // comparator levels come from the analog domain
  ssrw_pin_filter #(
    .FILTER_CYCLES(1)
  ) u_below (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .pin_in(supply_below_trip_in),
    .level_out(below_lvl),
    .rise_out(),
    .fall_out()
  );

  ssrw_pin_filter #(
    .FILTER_CYCLES(1)
  ) u_above (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .pin_in(supply_above_hyst_in),
    .level_out(above_lvl),
    .rise_out(),
    .fall_out()
  );

  // push-button input, glitch filtered
  ssrw_pin_filter #(
    .FILTER_CYCLES(MR_FILTER_CYCLES)
  ) u_manual (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .pin_in(manual_reset_n_in | ~HAS_MANUAL),
    .level_out(manual_lvl),
    .rise_out(),
    .fall_out()
  );

  // watchdog input, edges only
  ssrw_pin_filter #(
    .FILTER_CYCLES(1)
  ) u_kick (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .pin_in(watchdog_kick_in),
    .level_out(),
    .rise_out(kick_rise),
    .fall_out(kick_fall)
  );

  always_comb begin
    logic cause;
    logic kick_edge;
    cause = 1'b0;
    kick_edge = kick_rise | kick_fall;
    state_next = state_reg;
    state_next.wd_timeout = 1'b0;

    // hysteresis: set below trip, clear only above trip plus hysteresis
    if (below_lvl) begin
      state_next.undervolt = 1'b1;
    end else if (above_lvl) begin
      state_next.undervolt = 1'b0;
    end

    // watchdog starts on the first falling edge
    if (HAS_WATCHDOG && kick_fall) begin
      state_next.wd_armed = 1'b1;
    end
    if (!state_reg.wd_armed || state_reg.active || kick_edge) begin
      state_next.wd_cnt = `SSRW_CNT_RESET;
    end else if (state_reg.wd_cnt >= WD_LAST) begin
      state_next.wd_cnt = `SSRW_CNT_RESET;
      state_next.wd_timeout = 1'b1;
    end else begin
      state_next.wd_cnt = state_reg.wd_cnt + `SSRW_CNT_W'(1);
    end

    // any cause asserts; manual high adds nothing
    cause = state_reg.undervolt | ~manual_lvl | state_reg.wd_timeout;

    if (cause) begin
      state_next.active = 1'b1;
      state_next.dly_cnt = `SSRW_CNT_RESET;
    end else if (state_reg.active) begin
      if (state_reg.dly_cnt >= DLY_LAST) begin
        state_next.active = 1'b0;
        state_next.dly_cnt = `SSRW_CNT_RESET;
      end else begin
        state_next.dly_cnt = state_reg.dly_cnt + `SSRW_CNT_W'(1);
      end
    end

    state_next.pins = drive_pins(state_next.active);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      // power-up: undervoltage assumed until supply proves good
      state_reg.undervolt <= 1'b1;
      state_reg.wd_armed <= 1'b0;
      state_reg.wd_timeout <= 1'b0;
      state_reg.wd_cnt <= `SSRW_CNT_RESET;
      state_reg.dly_cnt <= `SSRW_CNT_RESET;
      state_reg.active <= 1'b1;
      state_reg.pins <= drive_pins(1'b1);
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign rst_n_out = state_reg.pins.rst_n;
  assign rst_n_oe_out = state_reg.pins.rst_n_oe;
  assign rst_n_pullup_out = state_reg.pins.rst_n_pullup;
  assign rst_out = state_reg.pins.rst;
  assign rst_oe_out = state_reg.pins.rst_oe;
  assign reset_active_out = state_reg.active;
  assign wd_armed_out = state_reg.wd_armed;

endmodule : ssrw_supervisor

`default_nettype wire

// ===== testbench/ssrw_checker_assertions.sv
// port checker for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module ssrw_checker #(
  parameter int unsigned WD_CYCLES = 200,
  parameter int unsigned RST_DELAY_CYCLES = 50
) (
  // clock and inputs
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic supply_below_trip_in,
  input wire logic supply_above_hyst_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_kick_in,
  // outputs
  input wire logic rst_n_out,
  input wire logic rst_n_oe_out,
  input wire logic rst_n_pullup_out,
  input wire logic rst_out,
  input wire logic rst_oe_out,
  input wire logic reset_active_out,
  input wire logic wd_armed_out
);
  logic clr;
  logic kick_reg;
  logic fall_seen_reg;
  int unsigned clr_cnt_reg;
  int unsigned hold_cnt_reg;
  int unsigned idle_cnt_reg;
  assign clr = manual_reset_n_in && !supply_below_trip_in && supply_above_hyst_in;
  always_ff @(posedge clk_in) begin
    kick_reg <= watchdog_kick_in;
    if (!reset_n_in) begin
      clr_cnt_reg <= 0;
      hold_cnt_reg <= 0;
      idle_cnt_reg <= 0;
      fall_seen_reg <= 1'b0;
    end else begin
      clr_cnt_reg <= clr ? clr_cnt_reg + 1 : 0;
      hold_cnt_reg <= (clr && reset_active_out) ? hold_cnt_reg + 1 : 0;
      idle_cnt_reg <= (kick_reg != watchdog_kick_in) ? 0 : idle_cnt_reg + 1;
      if (kick_reg && !watchdog_kick_in) begin
        fall_seen_reg <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_dual; rst_n_out == !rst_out; endproperty
  a_dual: assert property (p_dual) else $error("outputs not complementary");
  property p_high; rst_out == reset_active_out; endproperty
  a_high: assert property (p_high) else $error("high output off state");
  property p_pins; rst_n_oe_out && rst_oe_out && !rst_n_pullup_out; endproperty
  a_pins: assert property (p_pins) else $error("drive style wrong");
  property p_below; (supply_below_trip_in && ce_in)[*6] |=> reset_active_out; endproperty
  a_below: assert property (p_below) else $error("low supply without reset");
  property p_manual; (!manual_reset_n_in && ce_in)[*8] |=> reset_active_out; endproperty
  a_manual: assert property (p_manual) else $error("button without reset");
  property p_hold; $fell(reset_active_out) |-> hold_cnt_reg >= RST_DELAY_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("release too early");
  property p_wdog; $rose(reset_active_out) && clr_cnt_reg >= 12 |-> idle_cnt_reg >= WD_CYCLES; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog fired early");
  property p_arm; $rose(wd_armed_out) |-> fall_seen_reg; endproperty
  a_arm: assert property (p_arm) else $error("armed without falling kick");
endmodule : ssrw_checker
bind ssrw_supervisor ssrw_checker #(.WD_CYCLES(WD_CYCLES), .RST_DELAY_CYCLES(RST_DELAY_CYCLES)) u_chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
  .supply_below_trip_in(supply_below_trip_in), .supply_above_hyst_in(supply_above_hyst_in),
  .manual_reset_n_in(manual_reset_n_in), .watchdog_kick_in(watchdog_kick_in),
  .rst_n_out(rst_n_out), .rst_n_oe_out(rst_n_oe_out), .rst_n_pullup_out(rst_n_pullup_out),
  .rst_out(rst_out), .rst_oe_out(rst_oe_out), .reset_active_out(reset_active_out),
  .wd_armed_out(wd_armed_out));
`default_nettype wire

// ===== testbench/ssrw_host_model.sv
// host pet source and push-button stand-in
`timescale 1ns/1ps
`default_nettype none
module ssrw_host_model #(
  parameter int unsigned KICK_GAP = 50
) (
  input wire logic clk_in,
  input wire logic kick_en_in,
  input wire logic press_in,
  output var logic kick_out,
  output logic mr_n_out
);
  int unsigned gap_reg;
  initial gap_reg = 0;
  initial kick_out = 1'b1;
  assign mr_n_out = !press_in;
  // first toggle falls, arming the watchdog
  always @(posedge clk_in) begin
    if (kick_en_in) begin
      gap_reg <= (gap_reg == KICK_GAP - 1) ? 0 : gap_reg + 1;
      if (gap_reg == KICK_GAP - 1) kick_out <= !kick_out;
    end
  end
endmodule : ssrw_host_model
`default_nettype wire

// ===== testbench/ssrw_supervisor_bench.sv
// bench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module ssrw_supervisor_bench;
  localparam int unsigned WD = 200;
  localparam int unsigned DLY = 50;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic below = 1'b0;
  logic above = 1'b0;
  logic kick_en = 1'b0;
  logic press = 1'b0;
  logic ce = 1'b1;
  logic mr_n, kick, rst_n, rst, active, armed;
  logic oe_n, pu, oe;
  int fails = 0;
  int n_checks = 0;
  int n;
  always #2 clk_in = ~clk_in;
  ssrw_host_model u_host (.clk_in(clk_in), .kick_en_in(kick_en), .press_in(press), .kick_out(kick), .mr_n_out(mr_n));
  ssrw_supervisor #(.DUAL_OUTPUT(1'b1), .WD_CYCLES(WD), .RST_DELAY_CYCLES(DLY), .MR_FILTER_CYCLES(4)) u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
    .supply_below_trip_in(below), .supply_above_hyst_in(above),
    .manual_reset_n_in(mr_n), .watchdog_kick_in(kick),
    .rst_n_out(rst_n), .rst_n_oe_out(oe_n), .rst_n_pullup_out(pu), .rst_out(rst), .rst_oe_out(oe),
    .reset_active_out(active), .wd_armed_out(armed));
  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %b want %b", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask : cyc
  task automatic pins(input logic exp);
    @(negedge clk_in);
    check(active, exp);
    check(rst, exp);
    check(rst_n, !exp);
    check(oe_n, 1'b1);
    check(pu, 1'b0);
    check(oe, 1'b1);
    @(posedge clk_in);
  endtask : pins
  task automatic wait_act(input logic lvl, output int c);
    c = 0;
    while (active !== lvl && c < 2000) begin
      @(negedge clk_in);
      c++;
    end
    @(posedge clk_in);
  endtask : wait_act
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial begin
    cyc(20);
    reset_n_in <= 1'b1;
    cyc(100);
    pins(1'b1);
    above <= 1'b1;
    wait_act(1'b0, n);
    check(n >= DLY && n <= DLY + 20, 1'b1);
    press <= 1'b1;
    cyc(2);
    press <= 1'b0;
    cyc(30);
    pins(1'b0);
    press <= 1'b1;
    cyc(20);
    pins(1'b1);
    press <= 1'b0;
    wait_act(1'b0, n);
    check(n >= DLY && n <= DLY + 20, 1'b1);
    below <= 1'b1;
    cyc(10);
    pins(1'b1);
    below <= 1'b0;
    above <= 1'b0;
    cyc(100);
    pins(1'b1);
    above <= 1'b1;
    wait_act(1'b0, n);
    check(n >= DLY && n <= DLY + 20, 1'b1);
    cyc(WD + 50);
    pins(1'b0);
    kick_en <= 1'b1;
    cyc(3 * WD);
    check(armed, 1'b1);
    pins(1'b0);
    ce <= 1'b0;
    kick_en <= 1'b0;
    cyc(WD + 50);
    pins(1'b0);
    ce <= 1'b1;
    kick_en <= 1'b1;
    cyc(WD);
    pins(1'b0);
    kick_en <= 1'b0;
    wait_act(1'b1, n);
    check(n >= WD - 50 && n <= WD + 20, 1'b1);
    wait_act(1'b0, n);
    check(n >= DLY && n <= DLY + 20, 1'b1);
    report_and_stop();
  end
endmodule : ssrw_supervisor_bench
`default_nettype wire
